// ==== tcoc_top.sv ====
`timescale 1ns/1ns
`include "tcoc_map.svh"

// Behaviour
// R1: Toggle mode inverts the output pin on every output change event after start.
// R2: Toggle mode ignores the output polarity setting.
// R3: Combination mode takes the active output level from the polarity setting.
// R4: A polarity change in combination mode applies at the next set or reset.
// R5: Writing the polarity setting alone never changes the present pin level.
// R6: Slave set after master interrupt is delayed one count clock.
// R7: Reset wins over set when both occur in the same cycle.
// R8: Interrupt output change and software output write together still give a correct pin.
// R9: Capture input is sampled on the operating clock, error up to one operating clock.
// R10: Master period and slave duty data load together at the master interrupt.
// R11: Software rewrites both PWM data values right after the master interrupt.
// R12: One-shot: master data after master interrupt, slave data after slave interrupt.
// R13: Software sets default level with output disabled, then enables before starting.
module tcoc_top #(
	parameter int DW = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Timer pins
	input wire logic capture_input_pin_i,
	output logic channel_output_pin_o,
	output logic channel_output_enable_o,
	// Interrupt
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [`TCOC_CTRL_BITS-1:0] ctrl_r, ctrl_nxt;
	logic [DW-1:0] mdata_r, mdata_nxt, sdata_r, sdata_nxt;
	logic [`TCOC_ST_BITS-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [31:0] rdat_nxt;
	logic ack_nxt, irq_nxt;
	logic take, wr, sw_out_wr;
	tcoc_pkg::tcoc_func_e func;
	logic run, comb_mode, pol;

	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = take && wb_we_i;
	assign sw_out_wr = wr && (wb_adr_i == `TCOC_OFF_OUT) && wb_sel_i[0];
	assign func = tcoc_pkg::tcoc_func_e'(ctrl_r[`TCOC_CTRL_FUNC_HI:`TCOC_CTRL_FUNC_LO]);
	assign run = ctrl_r[`TCOC_CTRL_RUN];
	assign comb_mode = ctrl_r[`TCOC_CTRL_OMODE];
	assign pol = ctrl_r[`TCOC_CTRL_POL];

	////////////////////////////////////////////////////////////////////////////////
	logic tick, m_load, m_exp, s_load, s_exp, s_en;
	logic [DW-1:0] mcnt, scnt;
	logic run_d_r, s_act_r, s_act_nxt, set_pend_r, set_pend_nxt, armed_r, armed_nxt;
	logic start, trig, master_irq, set_ev, rst_ev;

	tcoc_prescale #(.PW(16)) u_pre (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cks_i(ctrl_r[`TCOC_CTRL_CKS_HI:`TCOC_CTRL_CKS_LO]),
		.tick_o(tick)
	);

	tcoc_down_counter #(.DW(DW)) u_master (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(m_load),
		.load_val_i(mdata_r),
		.tick_i(tick),
		.en_i(run && armed_r),
		.count_o(mcnt),
		.expire_o(m_exp)
	);

	tcoc_down_counter #(.DW(DW)) u_slave (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(s_load),
		.load_val_i(sdata_r),
		.tick_i(tick),
		.en_i(s_en),
		.count_o(scnt),
		.expire_o(s_exp)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Capture input is looked at only on the operating clock tick
	logic cap_smp_r, cap_smp_nxt, cap_prev_r, cap_prev_nxt, cap_ev;
	logic [DW-1:0] cap_cnt_r, cap_cnt_nxt, capt_r, capt_nxt;

	always_comb begin
		cap_smp_nxt = tick ? capture_input_pin_i : cap_smp_r; // R9
		cap_prev_nxt = tick ? cap_smp_r : cap_prev_r;
		cap_ev = tick && run && (func == tcoc_pkg::TCOC_FN_CAPTURE) && (cap_smp_r != cap_prev_r)
			&& (cap_smp_r || ctrl_r[`TCOC_CTRL_WIDTH]); // R9
		cap_cnt_nxt = cap_cnt_r;
		capt_nxt = capt_r;
		if (cap_ev) begin
			capt_nxt = cap_cnt_r;
			cap_cnt_nxt = '0;
		end else if (tick && run) begin
			cap_cnt_nxt = cap_cnt_r + DW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_smp_r <= 1'b0;
			cap_prev_r <= 1'b0;
			cap_cnt_r <= '0;
			capt_r <= '0;
		end else begin
			cap_smp_r <= cap_smp_nxt;
			cap_prev_r <= cap_prev_nxt;
			cap_cnt_r <= cap_cnt_nxt;
			capt_r <= capt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel sequencing: PWM reloads each period, one-shot fires once per trigger edge
	always_comb begin
		start = run && !run_d_r;
		trig = (func == tcoc_pkg::TCOC_FN_ONESHOT) && tick && run && cap_smp_r && !cap_prev_r && !armed_r;
		master_irq = m_exp && (func != tcoc_pkg::TCOC_FN_CAPTURE);
		armed_nxt = armed_r;
		unique case (func)
			tcoc_pkg::TCOC_FN_PWM: armed_nxt = run;
			tcoc_pkg::TCOC_FN_ONESHOT: begin
				if (trig) begin
					armed_nxt = 1'b1;
				end else if (master_irq || !run) begin
					armed_nxt = 1'b0;
				end
			end
			default: armed_nxt = 1'b0;
		endcase
		m_load = (start && func == tcoc_pkg::TCOC_FN_PWM) || trig
			|| (master_irq && func == tcoc_pkg::TCOC_FN_PWM);
		s_load = master_irq; // R10
		s_act_nxt = s_load ? 1'b1 : (s_exp ? 1'b0 : s_act_r);
		s_en = s_act_r && run;
		set_pend_nxt = master_irq ? 1'b1 : ((tick || !run) ? 1'b0 : set_pend_r);
		set_ev = set_pend_r && tick && run; // R6
		rst_ev = s_exp;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_d_r <= 1'b0;
			armed_r <= 1'b0;
			s_act_r <= 1'b0;
			set_pend_r <= 1'b0;
		end else begin
			run_d_r <= run;
			armed_r <= armed_nxt;
			s_act_r <= s_act_nxt;
			set_pend_r <= set_pend_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output level; polarity is only consulted when a set or reset happens
	logic out_r, out_nxt, oen_nxt;

	always_comb begin
		out_nxt = out_r;
		if (sw_out_wr) begin
			out_nxt = wb_dat_i[0];
		end
		if (!comb_mode) begin
			if (master_irq) begin
				out_nxt = !out_nxt; // R1 R2 R8
			end
		end else if (rst_ev) begin
			out_nxt = pol; // R3 R4 R7 R8
		end else if (set_ev) begin
			out_nxt = !pol; // R3 R4
		end
		oen_nxt = ctrl_nxt[`TCOC_CTRL_OEN];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_r <= 1'b0;
			channel_output_enable_o <= 1'b0;
		end else begin
			out_r <= out_nxt; // R5
			channel_output_enable_o <= oen_nxt;
		end
	end

	assign channel_output_pin_o = out_r;

	////////////////////////////////////////////////////////////////////////////////
	// Register file; unmapped reads give zero and unmapped writes are dropped
	logic [`TCOC_ST_BITS-1:0] ev, clr;
	logic [31:0] mrg;

	always_comb begin
		ctrl_nxt = ctrl_r;
		mdata_nxt = mdata_r;
		sdata_nxt = sdata_r;
		mask_nxt = mask_r;
		clr = '0;
		mrg = 32'h0000_0000;
		rdat_nxt = wb_dat_o;
		ev = '0;
		ev[`TCOC_ST_MASTER] = master_irq;
		ev[`TCOC_ST_SLAVE] = s_exp;
		ev[`TCOC_ST_CAPT] = cap_ev;
		if (wr) begin
			unique case (wb_adr_i)
				`TCOC_OFF_CTRL: begin
					mrg = merge(32'(ctrl_r), wb_dat_i, wb_sel_i);
					ctrl_nxt = mrg[`TCOC_CTRL_BITS-1:0];
				end
				`TCOC_OFF_MDATA: begin
					mrg = merge(32'(mdata_r), wb_dat_i, wb_sel_i);
					mdata_nxt = mrg[DW-1:0];
				end
				`TCOC_OFF_SDATA: begin
					mrg = merge(32'(sdata_r), wb_dat_i, wb_sel_i);
					sdata_nxt = mrg[DW-1:0];
				end
				`TCOC_OFF_STAT: clr = wb_sel_i[0] ? wb_dat_i[`TCOC_ST_BITS-1:0] : '0;
				`TCOC_OFF_MASK: mask_nxt = wb_sel_i[0] ? wb_dat_i[`TCOC_ST_BITS-1:0] : mask_r;
				default: ;
			endcase
		end
		stat_nxt = (stat_r & ~clr) | ev;
		if (take) begin
			unique case (wb_adr_i)
				`TCOC_OFF_CTRL: rdat_nxt = 32'(ctrl_r);
				`TCOC_OFF_MDATA: rdat_nxt = 32'(mdata_r);
				`TCOC_OFF_SDATA: rdat_nxt = 32'(sdata_r);
				`TCOC_OFF_OUT: rdat_nxt = 32'(out_r);
				`TCOC_OFF_STAT: rdat_nxt = 32'(stat_r);
				`TCOC_OFF_MASK: rdat_nxt = 32'(mask_r);
				`TCOC_OFF_CAPT: rdat_nxt = 32'(capt_r);
				`TCOC_OFF_CNT: rdat_nxt = 32'(mcnt);
				default: rdat_nxt = 32'h0000_0000;
			endcase
		end
		ack_nxt = take;
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `TCOC_CTRL_RST;
			mdata_r <= `TCOC_DATA_RST;
			sdata_r <= `TCOC_DATA_RST;
			stat_r <= '0;
			mask_r <= `TCOC_MASK_RST;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			mdata_r <= mdata_nxt;
			sdata_r <= sdata_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			wb_dat_o <= rdat_nxt;
			wb_ack_o <= ack_nxt;
			irq_o <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_master_pwm;
		master_irq && comb_mode && func == tcoc_pkg::TCOC_FN_PWM;
	endsequence

	sequence s_set_at_tick;
		set_pend_r && tick && run && comb_mode && !rst_ev;
	endsequence

	chk_toggle_invert: assert property (!comb_mode && master_irq && !sw_out_wr |=> out_r != $past(out_r)) // R1
		else $error("toggle mode did not invert output");
	chk_toggle_nopol: assert property (!comb_mode && !master_irq && !sw_out_wr |=> $stable(out_r)) // R2
		else $error("toggle mode output moved without event");
	chk_comb_active: assert property (comb_mode && set_ev && !rst_ev |=> out_r == !$past(pol)) // R3
		else $error("set level does not follow polarity");
	chk_pol_deferred: assert property (comb_mode && !set_ev && !rst_ev && !sw_out_wr |=> $stable(out_r)) // R4 R5
		else $error("output changed without a change condition");
	chk_set_delay: assert property (s_master_pwm ##1 s_set_at_tick |=> out_r == !$past(pol)) // R6
		else $error("set was not deferred by one count clock");
	chk_reset_wins: assert property (comb_mode && set_ev && rst_ev |=> out_r == $past(pol)) // R7
		else $error("reset did not win over set");
	chk_sw_collide: assert property (!comb_mode && master_irq && sw_out_wr |=> out_r == !$past(wb_dat_i[0])) // R8
		else $error("software write and toggle collided badly");
	chk_capture_tick: assert property ($changed(cap_smp_r) |-> $past(tick)) // R9
		else $error("capture input sampled off the operating clock");
	chk_reload_pair: assert property (master_irq && func == tcoc_pkg::TCOC_FN_PWM
		|=> mcnt == $past(mdata_r) && scnt == $past(sdata_r)) // R10
		else $error("period and duty not reloaded together");
	chk_irq_level: assert property (|(stat_r & mask_r) |-> ##[0:1] irq_o)
		else $error("unmasked status without interrupt");
endmodule

// ==== tcoc_map.svh ====
`ifndef TCOC_MAP_SVH
`define TCOC_MAP_SVH

// Register byte offsets
`define TCOC_OFF_CTRL 8'h00
`define TCOC_OFF_MDATA 8'h04
`define TCOC_OFF_SDATA 8'h08
`define TCOC_OFF_OUT 8'h0C
`define TCOC_OFF_STAT 8'h10
`define TCOC_OFF_MASK 8'h14
`define TCOC_OFF_CAPT 8'h18
`define TCOC_OFF_CNT 8'h1C

// Control register fields
`define TCOC_CTRL_RUN 0
`define TCOC_CTRL_OMODE 1
`define TCOC_CTRL_POL 2
`define TCOC_CTRL_OEN 3
`define TCOC_CTRL_CKS_LO 4
`define TCOC_CTRL_CKS_HI 7
`define TCOC_CTRL_FUNC_LO 8
`define TCOC_CTRL_FUNC_HI 9
`define TCOC_CTRL_WIDTH 10
`define TCOC_CTRL_BITS 11

// Status and mask fields
`define TCOC_ST_MASTER 0
`define TCOC_ST_SLAVE 1
`define TCOC_ST_CAPT 2
`define TCOC_ST_BITS 3

// Reset values
`define TCOC_CTRL_RST 11'h000
`define TCOC_DATA_RST 16'h0000
`define TCOC_MASK_RST 3'h0

`endif

// ==== tcoc_pkg.sv ====
package tcoc_pkg;

	typedef enum logic [1:0] {
		TCOC_FN_PWM = 2'b00,
		TCOC_FN_ONESHOT = 2'b01,
		TCOC_FN_CAPTURE = 2'b10
	} tcoc_func_e;

	typedef logic [15:0] tcoc_data_t;

endpackage

// ==== tcoc_prescale.sv ====
`timescale 1ns/1ns

module tcoc_prescale #(
	parameter int PW = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Divider control
	input wire logic [3:0] cks_i,
	output logic tick_o
);
	logic [PW-1:0] cnt_r;
	logic [PW-1:0] cnt_nxt;
	logic tick_nxt;
	logic [PW-1:0] top;

	// Operating clock is clk_i divided by two to the power cks
	always_comb begin
		top = PW'((32'h0000_0001 << cks_i) - 32'h0000_0001);
		// Greater-or-equal so that lowering cks mid-run does not wait for a counter wrap
		tick_nxt = (cnt_r >= top);
		cnt_nxt = tick_nxt ? '0 : cnt_r + PW'(1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_o <= tick_nxt;
		end
	end
endmodule

// ==== tcoc_down_counter.sv ====
`timescale 1ns/1ns

module tcoc_down_counter #(
	parameter int DW = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic load_i,
	input wire logic [DW-1:0] load_val_i,
	input wire logic tick_i,
	input wire logic en_i,
	// Status
	output logic [DW-1:0] count_o,
	output logic expire_o
);
	logic [DW-1:0] count_nxt;

	// Expiry is seen even in a load cycle, so a reload never hides a reset
	always_comb begin
		expire_o = tick_i && en_i && (count_o == '0);
		count_nxt = count_o;
		if (load_i) begin
			count_nxt = load_val_i;
		end else if (tick_i && en_i && count_o != '0) begin
			count_nxt = count_o - DW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= '0;
		end else begin
			count_o <= count_nxt;
		end
	end
endmodule

// ==== tcoc_pin_ext.sv ====
`timescale 1ns/1ns

module tcoc_pin_ext #(
	parameter int HALF = 5
) (
	// Clock
	input wire logic clk_i,
	// Source control
	input wire logic en_i,
	// Capture pin drive
	output logic pin_o
);
	int n;
	// Pull-down on the line: an idle source reads low
	initial begin
		pin_o = 1'b0;
		n = 0;
	end
	always @(posedge clk_i) begin
		if (!en_i) begin
			pin_o <= 1'b0;
			n <= 0;
		end else if (n == HALF - 1) begin
			pin_o <= ~pin_o;
			n <= 0;
		end else begin
			n <= n + 1;
		end
	end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
`include "tcoc_map.svh"

module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] q;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic ext_en = 1'b0;
	logic cap_pin;
	logic channel_output_pin_o;
	logic channel_output_enable_o;
	logic irq_o;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int hi;
	int tg;
	logic p;

	always #2 clk_i = ~clk_i;

	tcoc_top tcoc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.capture_input_pin_i(cap_pin), .channel_output_pin_o(channel_output_pin_o),
		.channel_output_enable_o(channel_output_enable_o), .irq_o(irq_o));
	tcoc_pin_ext tcoc_pin_ext_inst (.clk_i(clk_i), .en_i(ext_en), .pin_o(cap_pin));

	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("compares=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic cycle: hold until ack is seen at an edge, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) miscompares++;
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	function automatic logic [31:0] cw(input logic [1:0] fn, input logic oen, pol, om, run);
		return {22'h00_0000, fn, 4'h0, oen, pol, om, run};
	endfunction

	// Samples the pin over 40 clock cycles: high count and edge count
	task automatic win;
		hi = 0;
		tg = 0;
		p = channel_output_pin_o;
		repeat (40) begin
			@(posedge clk_i);
			hi += (channel_output_pin_o === 1'b1);
			tg += (channel_output_pin_o !== p);
			p = channel_output_pin_o;
		end
	endtask

	task automatic pwm(input logic [31:0] s, input logic pol, input int exp);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, pol, 1, 0));
		wb(1, `TCOC_OFF_MDATA, 32'h0000_0003);
		wb(1, `TCOC_OFF_SDATA, s);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, pol, 1, 1));
		repeat (12) @(posedge clk_i);
		win();
		check(hi, exp);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		wb(0, `TCOC_OFF_CTRL, 0);
		check(q, 32'h0000_0000);
		wb(0, `TCOC_OFF_OUT, 0);
		check(q, 32'h0000_0000);
		wb(0, `TCOC_OFF_MASK, 0);
		check(q, 32'h0000_0000);
		wb(0, 8'h40, 0);
		check(q, 32'h0000_0000);
		check(irq_o, 1'b0);
		$display("reset test done");
	endtask

	task automatic t_toggle;
		wb(1, `TCOC_OFF_MDATA, 32'h0000_0003);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 0, 1, 0, 0));
		wb(1, `TCOC_OFF_OUT, 32'h0000_0000);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, 1, 0, 0));
		check(channel_output_enable_o, 1'b1);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, 1, 0, 1));
		repeat (8) @(posedge clk_i);
		win();
		check(tg, 10);
		check(hi, 20);
		// Land a software write on the cycle of the next toggle
		p = channel_output_pin_o;
		while (channel_output_pin_o === p && cycles < 19000) @(posedge clk_i);
		repeat (2) @(posedge clk_i);
		wb(1, `TCOC_OFF_OUT, 32'h0000_0001);
		check(channel_output_pin_o, 1'b0);
		wb(0, `TCOC_OFF_STAT, 0);
		check(q[0], 1'b1);
		check(irq_o, 1'b0);
		wb(1, `TCOC_OFF_MASK, 32'h0000_0001);
		repeat (6) @(posedge clk_i);
		check(irq_o, 1'b1);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, 1, 0, 0));
		wb(1, `TCOC_OFF_STAT, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		check(irq_o, 1'b0);
		$display("toggle test done");
	endtask

	task automatic t_pwm;
		pwm(32'h0000_0001, 1'b0, 10);
		pwm(32'h0000_0001, 1'b1, 30);
		pwm(32'h0000_0000, 1'b0, 0);
		pwm(32'h0000_0005, 1'b0, 40);
		pwm(32'h0000_0001, 1'b0, 10);
		// Slow ticks leave room for both writes inside one period
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, 0, 1, 1) | 32'h0000_0030);
		wb(1, `TCOC_OFF_STAT, 32'h0000_0007);
		while (irq_o !== 1'b1 && cycles < 19000) @(posedge clk_i);
		wb(1, `TCOC_OFF_MDATA, 32'h0000_0007);
		wb(1, `TCOC_OFF_SDATA, 32'h0000_0003);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, 0, 1, 1));
		repeat (16) @(posedge clk_i);
		win();
		check(hi, 15);
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, 0, 1, 0));
		p = channel_output_pin_o;
		wb(1, `TCOC_OFF_CTRL, cw(2'b00, 1, 1, 1, 0));
		repeat (3) @(posedge clk_i);
		check(channel_output_pin_o, p);
		$display("pwm test done");
	endtask

	task automatic t_capture;
		wb(1, `TCOC_OFF_CTRL, cw(2'b10, 0, 0, 0, 1));
		ext_en <= 1'b1;
		repeat (60) @(posedge clk_i);
		wb(0, `TCOC_OFF_CAPT, 0);
		// Sampling on the tick allows one tick of error either way
		check(q >= 32'h0000_0009 && q <= 32'h0000_000B, 1'b1);
		wb(1, `TCOC_OFF_CTRL, cw(2'b10, 0, 0, 0, 1) | 32'h0000_0400);
		repeat (30) @(posedge clk_i);
		wb(0, `TCOC_OFF_CAPT, 0);
		check(q >= 32'h0000_0004 && q <= 32'h0000_0006, 1'b1);
		ext_en <= 1'b0;
		$display("capture test done");
	endtask

	task automatic t_oneshot;
		wb(1, `TCOC_OFF_CTRL, cw(2'b01, 1, 0, 1, 0));
		wb(1, `TCOC_OFF_MDATA, 32'h0000_0002);
		wb(1, `TCOC_OFF_SDATA, 32'h0000_0003);
		wb(1, `TCOC_OFF_CTRL, cw(2'b01, 1, 0, 1, 1));
		ext_en <= 1'b1;
		repeat (20) @(posedge clk_i);
		win();
		check(hi, 12);
		wb(1, `TCOC_OFF_CTRL, cw(2'b01, 1, 0, 1, 0));
		ext_en <= 1'b0;
		$display("one-shot test done");
	endtask

	////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_toggle();
		t_pwm();
		t_capture();
		t_oneshot();
		finish_test();
	end
endmodule
